// [rtl/copr_regs.sv]
// card-side register bank centred on the operating-conditions register
//
// How it works
// - a 32-bit operating word shows the supply windows and power-up flag.
// - bit 31 reads 0 while busy, becomes 1 once initialisation completes.
// - bit 24 shows the 1.8V switch acceptance, zero after reset.
// - bits 23 to 15 flag the supported 0.1V supply windows as ones.
// - bits 29-25 and 14-0, bit 7 included, always read zero.
// - identity 128, card data 128, address 16, features 64, status 512 bits.
// - the driver-stage register is absent; reading it is refused.
`timescale 1ns/1ps
`include "copr_consts.svh"

module copr_regs
    import copr_pkg::*;
(
    input  wire logic                        sys_clk,
    input  wire logic                        srst,
    input  wire logic                        initDone,
    input  wire logic                        capacityHigh,
    input  wire logic                        switchAccept,
    input  wire logic                        rdReq,
    input  wire logic [2:0]                  rdSel,
    input  wire logic [`COPR_WIDX_BITS-1:0]  rdWord,
    output logic      [`COPR_WORD_BITS-1:0]  rdData,
    output logic                             rdValid,
    output logic                             rdErr,
    input  wire logic                        memWrEn,
    input  wire logic [2:0]                  memWrSel,
    input  wire logic [`COPR_WIDX_BITS-1:0]  memWrWord,
    input  wire logic [`COPR_WORD_BITS-1:0]  memWrData,
    input  wire logic                        relAddrWrEn,
    input  wire logic [`COPR_RADDR_BITS-1:0] relAddrWrData,
    output logic      [`COPR_OPC_BITS-1:0]   opCondValue,
    output logic      [`COPR_RADDR_BITS-1:0] relAddrValue,
    output logic                             powerUpDone
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------

    // number of 32-bit words each selector holds
    function automatic logic [4:0] wordLimit(input logic [2:0] sel);
        logic [4:0] lim;
        lim = 5'h00;
        unique case (sel)
            COPR_SEL_OPC:   lim = `COPR_ONE_WORD;
            COPR_SEL_IDENT: lim = `COPR_IDENT_WORDS;
            COPR_SEL_CDATA: lim = `COPR_CDATA_WORDS;
            COPR_SEL_RADDR: lim = `COPR_ONE_WORD;
            COPR_SEL_DSR:   lim = 5'h00; // absent register
            COPR_SEL_FEAT:  lim = `COPR_FEAT_WORDS;
            COPR_SEL_STAT:  lim = `COPR_STAT_WORDS;
            default:        lim = 5'h00;
        endcase
        return lim;
    endfunction

    // first memory word of a memory-backed selector
    function automatic logic [4:0] memBase(input logic [2:0] sel);
        logic [4:0] base;
        base = `COPR_IDENT_BASE;
        unique case (sel)
            COPR_SEL_CDATA: base = `COPR_CDATA_BASE;
            COPR_SEL_FEAT:  base = `COPR_FEAT_BASE;
            COPR_SEL_STAT:  base = `COPR_STAT_BASE;
            default:        base = `COPR_IDENT_BASE;
        endcase
        return base;
    endfunction

    // selectors whose words live in the memory
    function automatic logic isMemSel(input logic [2:0] sel);
        return (sel == COPR_SEL_IDENT) || (sel == COPR_SEL_CDATA) ||
               (sel == COPR_SEL_FEAT) || (sel == COPR_SEL_STAT);
    endfunction

    // word index inside the selector's size
    function automatic logic inRange(input logic [2:0] sel,
                                     input logic [3:0] word);
        return {1'b0, word} < wordLimit(sel);
    endfunction

    // ------------------------------------------------------------------
    // power-up state and operating-conditions fields
    // ------------------------------------------------------------------
    copr_pwr_t                  pwr_q;
    logic                       ccs_q;
    logic                       lowVolt_q;
    logic [`COPR_OPC_BITS-1:0]  opCond_d;
    logic [`COPR_OPC_BITS-1:0]  opCond_q;

    // busy until the init engine reports completion; only srst (a power
    // cycle) brings the card back to busy
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pwr_q <= COPR_PWR_BUSY;
        end else begin
            unique case (pwr_q)
                COPR_PWR_BUSY:  pwr_q <= initDone ? COPR_PWR_READY
                                                  : COPR_PWR_BUSY;
                COPR_PWR_READY: pwr_q <= COPR_PWR_READY;
            endcase
        end
    end

    // capacity is latched as power-up ends, so it cannot move afterwards
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ccs_q <= 1'b0; // standard card until told otherwise
        end else if (pwr_q == COPR_PWR_BUSY && initDone) begin
            ccs_q <= capacityHigh;
        end
    end

    // sticky acceptance of the low-voltage switch
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lowVolt_q <= 1'b0;
        end else if (switchAccept) begin
            lowVolt_q <= 1'b1;
        end
    end

    // assemble the word; every bit not written here stays zero
    always_comb begin
        opCond_d = '0; // reserved fields
        opCond_d[`COPR_OPC_WIN_HI:`COPR_OPC_WIN_LO] =
            `COPR_OPC_WIN_SUPPORTED;
        opCond_d[`COPR_OPC_LOWV_BIT] = lowVolt_q;
        opCond_d[`COPR_OPC_BUSY_BIT] = (pwr_q == COPR_PWR_READY);
        // capacity is only meaningful once ready, so hide it while busy
        opCond_d[`COPR_OPC_CCS_BIT] = ccs_q && (pwr_q == COPR_PWR_READY);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            opCond_q <= `COPR_OPC_RESET;
        end else begin
            opCond_q <= opCond_d;
        end
    end

    assign opCondValue = opCond_q;
    assign powerUpDone = opCond_q[`COPR_OPC_BUSY_BIT];

    // ------------------------------------------------------------------
    // relative address register
    // ------------------------------------------------------------------
    logic [`COPR_RADDR_BITS-1:0] relAddr_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            relAddr_q <= '0;
        end else if (relAddrWrEn) begin
            relAddr_q <= relAddrWrData;
        end
    end

    assign relAddrValue = relAddr_q;

    // ------------------------------------------------------------------
    // word memory for identity, card data, features and status
    // ------------------------------------------------------------------
    logic                        memWrGo;
    logic                        memRdGo;
    logic [`COPR_ADDR_BITS-1:0]  memWrAddr;
    logic [`COPR_ADDR_BITS-1:0]  memRdAddr;
    logic [`COPR_WORD_BITS-1:0]  memRdData;

    // out-of-range loads are dropped so one block cannot spill into the next
    assign memWrGo   = memWrEn && isMemSel(memWrSel) &&
                       inRange(memWrSel, memWrWord);
    assign memWrAddr = memBase(memWrSel) + {1'b0, memWrWord};
    assign memRdGo   = rdReq && isMemSel(rdSel) && inRange(rdSel, rdWord);
    assign memRdAddr = memBase(rdSel) + {1'b0, rdWord};

    copr_word_mem copr_word_mem_inst (
        .sys_clk (sys_clk),
        .wrEn    (memWrGo),
        .wrAddr  (memWrAddr),
        .wrData  (memWrData),
        .rdEn    (memRdGo),
        .rdAddr  (memRdAddr),
        .rdData  (memRdData)
    );

    // ------------------------------------------------------------------
    // read pipeline: request, then memory access, then answer
    // ------------------------------------------------------------------
    logic       pend_q;
    logic       pendErr_q;
    logic [2:0] pendSel_q;

    // first stage remembers what was asked while the memory reads
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pend_q    <= 1'b0;
            pendErr_q <= 1'b0;
            pendSel_q <= 3'h0;
        end else begin
            pend_q    <= rdReq;
            pendErr_q <= rdReq && !inRange(rdSel, rdWord);
            pendSel_q <= rdSel;
        end
    end

    // second stage; the operating word is taken as it stands one cycle
    // after the request, so a flag that changes then is already visible
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdValid <= 1'b0;
            rdErr   <= 1'b0;
            rdData  <= '0;
        end else begin
            rdValid <= pend_q && !pendErr_q;
            rdErr   <= pend_q && pendErr_q;
            if (pend_q && !pendErr_q) begin
                if (pendSel_q == COPR_SEL_OPC) begin
                    rdData <= opCond_q;
                end else if (pendSel_q == COPR_SEL_RADDR) begin
                    rdData <= {16'h0000, relAddr_q};
                end else begin
                    rdData <= memRdData;
                end
            end else begin
                rdData <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_busy_release: assert property (
        @(posedge sys_clk) disable iff (srst)
        $rose(opCondValue[31]) |-> $past(initDone, 2)
    ) else $error("busy bit set without init completion");

    a_ready_holds: assert property (
        @(posedge sys_clk) disable iff (srst)
        initDone |-> ##2 opCondValue[31] [*3]
    ) else $error("busy bit did not rise and stay after init");

    a_lowv_follows: assert property (
        @(posedge sys_clk) disable iff (srst)
        $rose(opCondValue[24]) |-> $past(switchAccept, 2)
    ) else $error("switch flag rose without acceptance");

    a_lowv_sets: assert property (
        @(posedge sys_clk) disable iff (srst)
        switchAccept |-> ##2 opCondValue[24]
    ) else $error("switch acceptance not shown");

    a_window_ones: assert property (
        @(posedge sys_clk) disable iff (srst)
        opCondValue[23:15] == 9'h1ff
    ) else $error("supply window bits not all set");

    a_reserved_zero: assert property (
        @(posedge sys_clk) disable iff (srst)
        opCondValue[29:25] == 5'h00 && opCondValue[14:0] == 15'h0000
    ) else $error("reserved operating bits not zero");

    a_ccs_while_busy: assert property (
        @(posedge sys_clk) disable iff (srst)
        !opCondValue[31] |-> !opCondValue[30]
    ) else $error("capacity bit set while busy");

    a_opc_answer: assert property (
        @(posedge sys_clk) disable iff (srst)
        rdReq && rdSel == COPR_SEL_OPC && rdWord == 4'h0 |->
            ##2 rdValid && rdData == $past(opCondValue)
    ) else $error("operating word read returned wrong data");

    a_dsr_refused: assert property (
        @(posedge sys_clk) disable iff (srst)
        rdReq && rdSel == COPR_SEL_DSR |-> ##2 rdErr && !rdValid
    ) else $error("driver-stage read was not refused");

    a_size_limit: assert property (
        @(posedge sys_clk) disable iff (srst)
        rdReq && rdSel == COPR_SEL_FEAT |->
            ##2 (rdErr == ($past(rdWord, 2) > 4'h1)) && (rdValid != rdErr)
    ) else $error("features register size not honoured");

endmodule

// [rtl/copr_consts.svh]
// constants for the card operating-conditions register bank
`ifndef COPR_CONSTS_SVH
`define COPR_CONSTS_SVH

// ----------------------------------------------------------------------
// register widths in bits
// ----------------------------------------------------------------------
`define COPR_WORD_BITS          32
`define COPR_OPC_BITS           32
`define COPR_IDENT_BITS         128
`define COPR_CDATA_BITS         128
`define COPR_RADDR_BITS         16
`define COPR_DSR_BITS           16
`define COPR_FEAT_BITS          64
`define COPR_STAT_BITS          512

// ----------------------------------------------------------------------
// word counts, derived from the widths except the literal single-word count
// ----------------------------------------------------------------------
`define COPR_ONE_WORD           5'h01
`define COPR_IDENT_WORDS        5'(`COPR_IDENT_BITS / `COPR_WORD_BITS)
`define COPR_CDATA_WORDS        5'(`COPR_CDATA_BITS / `COPR_WORD_BITS)
`define COPR_FEAT_WORDS         5'(`COPR_FEAT_BITS / `COPR_WORD_BITS)
`define COPR_STAT_WORDS         5'(`COPR_STAT_BITS / `COPR_WORD_BITS)

// ----------------------------------------------------------------------
// operating-conditions field positions and values
// ----------------------------------------------------------------------
`define COPR_OPC_BUSY_BIT       31
`define COPR_OPC_CCS_BIT        30
`define COPR_OPC_LOWV_BIT       24
`define COPR_OPC_WIN_HI         23
`define COPR_OPC_WIN_LO         15
`define COPR_OPC_WIN_SUPPORTED  9'h1ff
`define COPR_OPC_RESET          32'h00ff8000

// ----------------------------------------------------------------------
// word memory layout
// ----------------------------------------------------------------------
`define COPR_ADDR_BITS          5
`define COPR_WIDX_BITS          4
`define COPR_MEM_DEPTH          32
`define COPR_IDENT_BASE         5'h00
`define COPR_CDATA_BASE         5'h04
`define COPR_FEAT_BASE          5'h08
`define COPR_STAT_BASE          5'h10

`endif

// [rtl/copr_pkg.sv]
// types shared by the card operating-conditions register bank
package copr_pkg;

    // register selector codes; code 3'h7 is unused
    typedef enum logic [2:0] {
        COPR_SEL_OPC   = 3'h0,
        COPR_SEL_IDENT = 3'h1,
        COPR_SEL_CDATA = 3'h2,
        COPR_SEL_RADDR = 3'h3,
        COPR_SEL_DSR   = 3'h4,
        COPR_SEL_FEAT  = 3'h5,
        COPR_SEL_STAT  = 3'h6
    } copr_sel_t;

    // power-up progress
    typedef enum logic {
        COPR_PWR_BUSY  = 1'b0,
        COPR_PWR_READY = 1'b1
    } copr_pwr_t;

endpackage

// [rtl/copr_word_mem.sv]
// word memory holding identity, card data, features and status words
`timescale 1ns/1ps
`include "copr_consts.svh"

module copr_word_mem (
    input  wire logic                        sys_clk,
    input  wire logic                        wrEn,
    input  wire logic [`COPR_ADDR_BITS-1:0]  wrAddr,
    input  wire logic [`COPR_WORD_BITS-1:0]  wrData,
    input  wire logic                        rdEn,
    input  wire logic [`COPR_ADDR_BITS-1:0]  rdAddr,
    output logic      [`COPR_WORD_BITS-1:0]  rdData
);

    logic [`COPR_WORD_BITS-1:0] mem [`COPR_MEM_DEPTH];

    // write port; contents have no reset, the loader fills them
    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // registered read so the data settle one cycle after the enable
    always_ff @(posedge sys_clk) begin
        if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

// [test/copr_host_model.sv]
// host-side model that fetches card registers over the read port
`timescale 1ns/1ps

module copr_host_model (
    input  wire logic        sys_clk,
    output logic             rdReq,
    output logic [2:0]       rdSel,
    output logic [3:0]       rdWord,
    input  wire logic [31:0] rdData,
    input  wire logic        rdValid,
    input  wire logic        rdErr
);
    // idle request lines; there is no driver-stage write path at all
    initial begin
        rdReq = 1'b0;
        rdSel = 3'h0;
        rdWord = 4'h0;
    end

    // one strobe, then a bounded wait so a dead card cannot hang us
    task automatic fetch(input logic [2:0] s, input logic [3:0] w,
                         output logic [31:0] d, output logic ok,
                         output logic er);
        int n;
        d = 32'h0;
        ok = 1'b0;
        er = 1'b0;
        @(posedge sys_clk);
        #1;
        rdReq = 1'b1;
        rdSel = s;
        rdWord = w;
        @(posedge sys_clk);
        #1;
        rdReq = 1'b0;
        rdSel = ~s;  // stale selector is scrambled
        rdWord = ~w;
        for (n = 0; n < 4; n++) begin
            if (rdValid === 1'b1 || rdErr === 1'b1) begin
                d = rdData;
                ok = rdValid;
                er = rdErr;
                break;
            end
            @(posedge sys_clk);
            #1;
        end
    endtask

    // repeat the query up to limit times until bit 31 shows; card stays 0 if it never does
    task automatic poll_ready(input int limit, output logic [31:0] d,
                              output logic card);
        logic ok;
        logic er;
        int   i;
        card = 1'b0;
        d = 32'h0;
        for (i = 0; i < limit; i++) begin
            fetch(3'h0, 4'h0, d, ok, er);
            if (ok === 1'b1 && d[31] === 1'b1) begin
                card = 1'b1;
                break;
            end
        end
    endtask
endmodule

// [test/tb_copr_regs.sv]
// self-checking bench for the card operating-conditions register bank
`timescale 1ns/1ps
`include "copr_consts.svh"

module tb_copr_regs;
    import copr_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        initDone = 1'b0;
    logic        capacityHigh = 1'b0;
    logic        switchAccept = 1'b0;
    logic        memWrEn = 1'b0;
    logic [2:0]  memWrSel = 3'h0;
    logic [3:0]  memWrWord = 4'h0;
    logic [31:0] memWrData = 32'h0;
    logic        relAddrWrEn = 1'b0;
    logic [15:0] relAddrWrData = 16'h0;
    logic        rdReq;
    logic [2:0]  rdSel;
    logic [3:0]  rdWord;
    logic [31:0] rdData;
    logic        rdValid;
    logic        rdErr;
    logic [31:0] opCondValue;
    logic [15:0] relAddrValue;
    logic        powerUpDone;
    int          failCount = 0;
    int          samplesChecked = 0;

    always #4 sys_clk = ~sys_clk;

    copr_regs copr_regs_inst (.sys_clk(sys_clk), .srst(srst),
        .initDone(initDone), .capacityHigh(capacityHigh),
        .switchAccept(switchAccept), .rdReq(rdReq), .rdSel(rdSel),
        .rdWord(rdWord), .rdData(rdData), .rdValid(rdValid),
        .rdErr(rdErr), .memWrEn(memWrEn), .memWrSel(memWrSel),
        .memWrWord(memWrWord), .memWrData(memWrData),
        .relAddrWrEn(relAddrWrEn), .relAddrWrData(relAddrWrData),
        .opCondValue(opCondValue), .relAddrValue(relAddrValue),
        .powerUpDone(powerUpDone));

    copr_host_model copr_host_model_inst (.sys_clk(sys_clk),
        .rdReq(rdReq), .rdSel(rdSel), .rdWord(rdWord), .rdData(rdData),
        .rdValid(rdValid), .rdErr(rdErr));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        samplesChecked++;
        if (exp !== got) begin
            failCount++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // a refused read must also carry zero data
    task automatic rd_expect(input logic [2:0] s, input logic [3:0] w,
                             input logic [31:0] exp, input logic expErr);
        logic [31:0] d;
        logic        ok;
        logic        er;
        copr_host_model_inst.fetch(s, w, d, ok, er);
        check("rdErr", {31'h0, expErr}, {31'h0, er});
        check("rdValid", {31'h0, ~expErr}, {31'h0, ok});
        check("rdData", exp, d);
    endtask

    task automatic load(input logic [2:0] s, input logic [3:0] w,
                        input logic [31:0] v);
        @(posedge sys_clk);
        #1;
        memWrEn = 1'b1;
        memWrSel = s;
        memWrWord = w;
        memWrData = v;
        @(posedge sys_clk);
        #1;
        memWrEn = 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // run is about 160 cycles; this allows 3000 cycles, over eighteen times that
    initial begin
        #(3000 * 8);
        failCount++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        logic [2:0]  sl [4];
        int          nw [4];
        logic [31:0] d;
        logic        card;
        int          i;
        int          w;
        sl = '{3'h1, 3'h2, 3'h5, 3'h6};
        nw = '{4, 4, 2, 16};
        repeat (20) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        check("opCondValue", 32'h00ff8000, opCondValue);
        check("powerUpDone", 32'h0, {31'h0, powerUpDone});
        rd_expect(3'h0, 4'h0, 32'h00ff8000, 1'b0);
        // capacity held high while busy must stay masked
        capacityHigh = 1'b1;
        switchAccept = 1'b1;
        @(posedge sys_clk);
        #1;
        switchAccept = 1'b0;
        rd_expect(3'h0, 4'h0, 32'h01ff8000, 1'b0);
        copr_host_model_inst.poll_ready(3, d, card);
        check("cardSeen", 32'h0, {31'h0, card});
        fork
            copr_host_model_inst.poll_ready(20, d, card);
            begin
                repeat (8) @(posedge sys_clk);
                #1;
                initDone = 1'b1;
                @(posedge sys_clk);
                #1;
                initDone = 1'b0;
            end
        join
        check("cardSeen", 32'h1, {31'h0, card});
        check("polledOpCond", 32'hc1ff8000, d);
        capacityHigh = 1'b0;
        rd_expect(3'h0, 4'h0, 32'hc1ff8000, 1'b0);
        check("powerUpDone", 32'h1, {31'h0, powerUpDone});
        // fill every word of each stored register, then read the ends
        for (i = 0; i < 4; i++) begin
            for (w = 0; w < nw[i]; w++) begin
                load(sl[i], w[3:0], {5'h15, sl[i], 20'h5a5a5, w[3:0]});
            end
        end
        for (i = 0; i < 4; i++) begin
            w = nw[i] - 1;
            rd_expect(sl[i], 4'h0, {5'h15, sl[i], 24'h5a5a50}, 1'b0);
            rd_expect(sl[i], w[3:0], {5'h15, sl[i], 20'h5a5a5, w[3:0]},
                      1'b0);
            if (nw[i] < 16) begin
                w = nw[i];
                rd_expect(sl[i], w[3:0], 32'h0, 1'b1);
            end
        end
        @(posedge sys_clk);
        #1;
        relAddrWrEn = 1'b1;
        relAddrWrData = 16'hbeef;
        @(posedge sys_clk);
        #1;
        relAddrWrEn = 1'b0;
        rd_expect(3'h3, 4'h0, 32'h0000beef, 1'b0);
        rd_expect(3'h3, 4'h1, 32'h0, 1'b1);
        rd_expect(3'h0, 4'h1, 32'h0, 1'b1);
        rd_expect(3'h4, 4'h0, 32'h0, 1'b1);
        rd_expect(3'h7, 4'h0, 32'h0, 1'b1);
        // a power cycle in mid-run returns every flag to its start value
        srst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        check("opCondValue", 32'h00ff8000, opCondValue);
        check("relAddrValue", 32'h0, {16'h0, relAddrValue});
        rd_expect(3'h0, 4'h0, 32'h00ff8000, 1'b0);
        tally_and_finish();
    end
endmodule
